// [secded_pkg.sv]
package secded_pkg;

  localparam int DATA_WIDTH    = 8;
  localparam int PARITY_COUNT  = 5;
  localparam int CODE_WIDTH    = DATA_WIDTH + PARITY_COUNT;
  localparam int HAMMING_COUNT = PARITY_COUNT - 1;
  localparam int FIRST_DATA_POS = 3;
  localparam int FIFO_DEPTH    = 4;
  localparam int LATENCY_ONE   = 1;
  localparam int LATENCY_TWO   = 2;
  localparam logic [CODE_WIDTH-1:0] CODE_RESET = 13'h0000;
  localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;

  typedef logic [DATA_WIDTH-1:0] data_t;
  typedef logic [CODE_WIDTH-1:0] code_t;

  typedef struct packed {
    logic  valid;
    data_t data;
  } data_beat_s;

  typedef struct packed {
    logic  valid;
    code_t code;
  } code_beat_s;

endpackage

// [code_fifo.sv]
`timescale 1ns/1ns
module code_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } fifo_state_s;

  fifo_state_s state;
  fifo_state_s next_state;
  logic        push;
  logic        pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (state.count != (AW+1)'(DEPTH));
  assign out_valid = (state.count != '0);
  assign out_data  = state.mem[state.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_state = state;
    if (push) begin
      next_state.mem[state.wr_ptr] = in_data;
      next_state.wr_ptr            = bump(state.wr_ptr);
    end
    if (pop) begin
      next_state.rd_ptr = bump(state.rd_ptr);
    end
    if (push && !pop) begin
      next_state.count = state.count + 1'b1;
    end else if (pop && !push) begin
      next_state.count = state.count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  a_fifo_no_overflow: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.count <= (AW+1)'(DEPTH))
    else $error("FIFO count above depth.");

endmodule // code_fifo

// [secded_hamming_encoder.sv]
`timescale 1ns/1ns
// Functional notes
// [R1] Eight data bits become a 13-bit code word with five generated parity bits.
// [R2] Power-of-two positions carry Hamming parity and the last position carries overall parity.
// [R3] Data bits fill the remaining positions upward, the lowest data bit at position three.
// [R4] Parity at position n skips n-1 positions, then alternately checks and skips n positions.
// [R5] The first parity bit is even parity of positions 3, 5, 7, 9 and 11.
// [R6] The second parity bit is even parity of positions 3, 6, 7, 10 and 11.
// [R7] The overall parity bit is even parity of positions 1 to 12, Hamming parity included.
// [R8] The output word holds data in its low bits and parity in its high bits.
// [R9] Data is taken and encoded at a rising edge only while the code clock enable is high.
// [R10] With two-cycle latency the word appears at the next edge that takes data after the encoding edge.
// [R11] With one-cycle latency the word appears at the encoding edge itself.
// [R12] While the code clock enable is low the output code word holds its value and the output valid flag clears; code_valid holds until the FIFO empties.
// [R13] The asynchronous clear sets every pipeline and output register to zero.
module secded_hamming_encoder
  import secded_pkg::*;
#(
  parameter int LATENCY    = secded_pkg::LATENCY_TWO,
  parameter int FIFO_WORDS = secded_pkg::FIFO_DEPTH
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  code_clk_en,
  input  wire secded_pkg::data_t     data_in,
  output logic                       data_ready,
  output secded_pkg::code_t          code_word,
  output logic                       code_valid,
  input  wire logic                  code_ready
);
  import secded_pkg::*;

  typedef struct packed {
    data_beat_s stage;
    code_beat_s out;
  } enc_state_s;

  enc_state_s state;
  enc_state_s next_state;
  code_t      encoded;
  code_t      stage_code;
  logic       fifo_in_ready;
  logic       take;
  logic       produced;

  function automatic logic is_pow2(input int pos);
    is_pow2 = (pos & (pos - 1)) == 0;
  endfunction

  function automatic code_t encode(input data_t d);
    logic [CODE_WIDTH:1] pos;
    logic [HAMMING_COUNT-1:0] ham;
    logic overall;
    int   k;
    pos     = '0;
    ham     = '0;
    overall = 1'b0;
    k       = 0;
    for (int p = 1; p < CODE_WIDTH; p++) begin
      if (!is_pow2(p)) begin
        pos[p] = d[k]; // [R3]
        k++;
      end
    end
    for (int i = 0; i < HAMMING_COUNT; i++) begin
      for (int p = FIRST_DATA_POS; p < CODE_WIDTH; p++) begin
        if (((p >> i) & 1) == 1) begin
          ham[i] = ham[i] ^ pos[p]; // [R4] [R5] [R6]
        end
      end
      pos[1 << i] = ham[i]; // [R2]
    end
    for (int p = 1; p < CODE_WIDTH; p++) begin
      overall = overall ^ pos[p]; // [R7]
    end
    encode = {overall, ham, d}; // [R1] [R8]
  endfunction

  assign encoded    = encode(data_in);
  assign stage_code = encode(state.stage.data);
  assign take       = code_clk_en && fifo_in_ready;
  assign data_ready = take;
  // Words enter the FIFO at the edge that makes them, so a take can never outrun the room.
  assign produced   = take && next_state.out.valid;

  always_comb begin
    next_state = state;
    if (take) begin
      next_state.stage.valid = 1'b1; // [R9]
      next_state.stage.data  = data_in;
      if (LATENCY == LATENCY_ONE) begin
        next_state.out.valid = 1'b1; // [R11]
        next_state.out.code  = encoded;
      end else begin
        next_state.out.valid = state.stage.valid; // [R10]
        next_state.out.code  = stage_code;
      end
    end else begin
      next_state.out.valid = 1'b0; // [R12]
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0; // [R13]
    end else begin
      state <= next_state;
    end
  end

  assign code_word = state.out.code;

  code_fifo #(
    .WIDTH (CODE_WIDTH),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (produced),
    .in_ready  (fifo_in_ready),
    .in_data   (next_state.out.code),
    .out_valid (code_valid),
    .out_ready (code_ready),
    .out_data  ()
  );

  a_word_layout: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R8]
    (code_clk_en && fifo_in_ready && LATENCY == LATENCY_ONE) |=>
      code_word[DATA_WIDTH-1:0] == $past(data_in))
    else $error("Data bits not in low part of code word.");

  a_overall_even: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R7]
    encoded[CODE_WIDTH-1] == (^encoded[CODE_WIDTH-2:0]))
    else $error("Overall parity is not even.");

  a_parity_one: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R5]
    encoded[DATA_WIDTH] == (data_in[0] ^ data_in[1] ^ data_in[3] ^ data_in[4] ^ data_in[6]))
    else $error("First parity bit wrong.");

  a_parity_two: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R6]
    encoded[DATA_WIDTH+1] == (data_in[0] ^ data_in[2] ^ data_in[3] ^ data_in[5] ^ data_in[6]))
    else $error("Second parity bit wrong.");

  a_known_vector: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R1]
    (data_in == 8'hf0) |-> encoded == 13'h14f0)
    else $error("Encoding of f0 is wrong.");

  a_hold_disabled: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R12]
    !code_clk_en |=> $stable(code_word) && !state.out.valid)
    else $error("Output changed while enable low.");

  a_two_cycle: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R10]
    (LATENCY == LATENCY_TWO && take ##1 take) |=> code_word == encode($past(data_in, 2)))
    else $error("Two-cycle latency word wrong.");

  a_one_cycle: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R11]
    (LATENCY == LATENCY_ONE && take) |=> code_word == encode($past(data_in)))
    else $error("One-cycle latency word wrong.");

  a_no_take_off: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R9]
    !code_clk_en |=> $stable(state.stage))
    else $error("Stage loaded while enable low.");

  a_parity_three: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R4]
    encoded[DATA_WIDTH+2] == (data_in[1] ^ data_in[2] ^ data_in[3] ^ data_in[7]))
    else $error("Third parity bit wrong.");

  a_parity_four: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R4]
    encoded[DATA_WIDTH+3] == (data_in[4] ^ data_in[5] ^ data_in[6] ^ data_in[7]))
    else $error("Fourth parity bit wrong.");

  a_reset_clear: assert property (@(posedge ref_clk) // [R13]
    !reset_n |-> state == '0)
    else $error("Registers not cleared in reset.");

  c_fifo_full:  cover property (@(posedge ref_clk) disable iff (!reset_n) !fifo_in_ready);
  c_two_takes:  cover property (@(posedge ref_clk) disable iff (!reset_n) take ##1 take);
  c_vector_fa:  cover property (@(posedge ref_clk) disable iff (!reset_n) encoded == 13'h06fa);
  c_enable_gap: cover property (@(posedge ref_clk) disable iff (!reset_n)
    code_clk_en ##1 !code_clk_en ##1 code_clk_en);

endmodule // secded_hamming_encoder

// [code_sink.sv]
`timescale 1ns/1ns
module code_sink (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic slow,
  input  wire logic code_valid,
  output logic      code_ready
);
  int seed = 32'hce5f;
  int taken;
  // Accepts on most cycles, and only now and then while slow is set.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      code_ready <= 1'b0;
      taken      <= 0;
    end else begin
      code_ready <= slow ? (($random(seed) & 7) == 0) : (($random(seed) & 3) != 0);
      if (code_valid && code_ready) begin
        taken <= taken + 1;
      end
    end
  end
endmodule // code_sink

// [tb_secded_hamming_encoder.sv]
`timescale 1ns/1ns
module tb_secded_hamming_encoder;
  import secded_pkg::*;
  localparam int CYCLE_LIMIT = 2000;
  logic  ref_clk        = 1'b0;
  logic  reset_n        = 1'b1;
  logic  code_clk_en    = 1'b0;
  logic  slow           = 1'b0;
  data_t data_in        = 8'h00;
  logic  data_ready;
  logic  data_ready_1;
  logic  code_valid;
  logic  code_valid_1;
  logic  code_ready;
  code_t code_word;
  code_t code_word_1;
  code_t stage;
  logic  stage_valid;
  code_t expect_word;
  code_t expect_word_1;
  int    expect_count;
  int    expect_count_1;
  int    n_pop;
  int    seed           = 32'hce5f;
  int    n_fail         = 0;
  int    check_count    = 0;
  int    cycles         = 0;

  always #2 ref_clk = ~ref_clk;

  secded_hamming_encoder #(.LATENCY(LATENCY_TWO)) secded_hamming_encoder_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .code_clk_en(code_clk_en), .data_in(data_in),
    .data_ready(data_ready), .code_word(code_word), .code_valid(code_valid),
    .code_ready(code_ready));

  // A second copy runs with one-cycle latency on the same stimulus.
  secded_hamming_encoder #(.LATENCY(LATENCY_ONE)) secded_hamming_encoder_lat1_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .code_clk_en(code_clk_en), .data_in(data_in),
    .data_ready(data_ready_1), .code_word(code_word_1), .code_valid(code_valid_1),
    .code_ready(code_ready));

  code_sink code_sink_i (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
    .code_valid(code_valid), .code_ready(code_ready));

  function automatic code_t encode(data_t d);
    logic [13:1] w;
    int k;
    w = '0;
    k = 0;
    for (int p = 3; p <= 12; p++) if ((p & (p - 1)) != 0) begin
      w[p] = d[k];
      k++;
    end
    for (int n = 1; n <= 8; n *= 2) for (int p = 3; p <= 12; p++)
      if ((p & (p - 1)) != 0 && (p & n) != 0) w[n] ^= w[p];
    w[13] = ^w[12:1];
    return {w[13], w[8], w[4], w[2], w[1], d};
  endfunction

  function automatic int next_count(int count, logic made);
    return count + int'(made) - int'(count != 0 && code_ready);
  endfunction

  // Reference model advances only on edges where its own FIFO count allows a take.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage          <= '0;
      stage_valid    <= 1'b0;
      expect_word    <= '0;
      expect_word_1  <= '0;
      expect_count   <= 0;
      expect_count_1 <= 0;
      n_pop          <= 0;
    end else begin
      if (code_clk_en && expect_count != FIFO_DEPTH) begin
        expect_word <= stage;
        stage       <= encode(data_in);
        stage_valid <= 1'b1;
      end
      if (code_clk_en && expect_count_1 != FIFO_DEPTH) begin
        expect_word_1 <= encode(data_in);
      end
      expect_count   <= next_count(expect_count,
                                   code_clk_en && expect_count != FIFO_DEPTH && stage_valid);
      expect_count_1 <= next_count(expect_count_1, code_clk_en && expect_count_1 != FIFO_DEPTH);
      n_pop          <= n_pop + int'(expect_count != 0 && code_ready);
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > CYCLE_LIMIT) begin
      $display("BAD %0t cycle limit reached", $time);
      n_fail++;
      summarize();
    end
  end

  task automatic check_num(int got, int exp, string what);
    check_count++;
    if (got != exp) begin
      n_fail++;
      $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic check(code_t got, code_t exp, string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(logic got, logic exp, string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic drive(logic en, data_t d);
    code_clk_en = en;
    data_in = d;
    @(posedge ref_clk);
    #1;
    check(code_word, expect_word, "word");
    check(code_word_1, expect_word_1, "word lat1");
    check_bit(data_ready, code_clk_en && expect_count != FIFO_DEPTH, "ready");
    check_bit(data_ready_1, code_clk_en && expect_count_1 != FIFO_DEPTH, "ready lat1");
    check_bit(code_valid, expect_count != 0, "valid");
    check_bit(code_valid_1, expect_count_1 != 0, "valid lat1");
    if (!code_clk_en) check_bit(data_ready, 1'b0, "ready with enable low");
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #1 reset_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    check(encode(8'hf0), 13'h14f0, "f0 vector");
    check(encode(8'hfa), 13'h06fa, "fa vector");
    drive(1'b1, 8'hf0);
    drive(1'b1, 8'hfa);
    drive(1'b1, 8'hfb);
    drive(1'b0, 8'h00);
    drive(1'b0, 8'h55);
    $display("corner walk done");
    slow = 1'b1;
    repeat (60) drive(1'($random(seed)) | 1'b1, 8'($random(seed)));
    $display("stalled fill done");
    slow = 1'b0;
    repeat (300) drive(1'($random(seed)), 8'($random(seed)));
    $display("random stream done");
    reset_n = 1'b0;
    #1;
    check(code_word, '0, "word in reset");
    check(code_word_1, '0, "word lat1 in reset");
    check_bit(code_valid, 1'b0, "valid in reset");
    @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (200) drive(1'($random(seed)), 8'($random(seed)));
    $display("after reset done");
    check_num(code_sink_i.taken, n_pop, "words drained");
    summarize();
  end
endmodule // tb_secded_hamming_encoder
